// >>> logic/dss_top.sv
// dss_top: run/stop, emergency unload, safe lamp, write guard, unit decode.
// assumes spindle and positioner status come from logic on mclk_i;
// panel switches and the external request line are asynchronous pins.
`timescale 1ns/1ps
module dss_top #(
  parameter int unsigned DEB_CYC    = dss_pkg::DEB_CYC,
  parameter bit          HAS_SWITCH = 1'b1,
  parameter logic [1:0]  FIXED_UNIT = dss_pkg::UNIT_DEF
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       run_stop_btn_i,
  input  wire logic       guard_upper_sw_i,
  input  wire logic       guard_lower_sw_i,
  input  wire logic       ext_retract_req_n_i,
  input  wire logic       cart_seated_i,
  input  wire logic       power_ok_i,
  input  wire logic       disk_rotating_i,
  input  wire logic       heads_retracted_i,
  input  wire logic       speed_fault_i,
  input  wire logic       pos_fault_i,
  input  wire logic       write_fault_i,
  input  wire logic       write_active_i,
  input  wire logic [1:0] unit_sw_i,
  input  wire logic       split_en_i,
  input  wire logic [3:0] unit_sel_n_i,
  input  wire logic       guard_pulse_n_i,
  input  wire logic [1:0] fixed_sel_i,
  input  wire logic       ctl_start_i,
  input  wire logic       removable_sel_i,
  output logic            run_lamp_o,
  output logic            spin_en_o,
  output logic            unload_o,
  output logic            safe_lamp_o,
  output logic            cart_lock_o,
  output logic            write_guard_lamp_upper_o,
  output logic            write_guard_lamp_lower_o,
  output logic            write_inhibit_o,
  output logic            selected_o,
  output logic            split_half_o
);

  ////////////////////////////////////////////////////////////////////////
  // synchronise and debounce asynchronous pins
  localparam int unsigned NSYN = 6;
  // resting pin levels: guard pulse and retract request idle high
  localparam logic [NSYN-1:0] PIN_IDLE = 6'h28;
  logic [NSYN-1:0] raw;
  logic [NSYN-1:0] s1_r, s2_r, s3_r;
  logic [NSYN-1:0] deb_r;
  logic [dss_pkg::DEB_W-1:0] cnt_r [NSYN];

  assign raw = {guard_pulse_n_i, cart_seated_i, ext_retract_req_n_i,
                guard_lower_sw_i, guard_upper_sw_i, run_stop_btn_i};

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s1_r <= PIN_IDLE;
      s2_r <= PIN_IDLE;
      s3_r <= PIN_IDLE;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // level accepted when stages 2 and 3 agree for the settle time
  always_ff @(posedge mclk_i) begin
    for (int i = 0; i < NSYN; i++) begin
      if (rst_i) begin
        cnt_r[i] <= '0;
        deb_r[i] <= PIN_IDLE[i];
      end else if (s2_r[i] != s3_r[i] || s3_r[i] == deb_r[i]) begin
        cnt_r[i] <= '0;
      end else if (cnt_r[i] >= dss_pkg::DEB_W'(DEB_CYC - 1)) begin
        cnt_r[i] <= '0;
        deb_r[i] <= s3_r[i];
      end else begin
        cnt_r[i] <= cnt_r[i] + 1'b1;
      end
    end
  end

  logic btn_d, up_sw, lo_sw, ext_req, seated, gpulse;
  assign btn_d   = deb_r[0];
  assign up_sw   = deb_r[1];
  assign lo_sw   = deb_r[2];
  assign ext_req = ~deb_r[3];
  assign seated  = deb_r[4];
  assign gpulse  = ~deb_r[5];

  logic btn_prev_r, gp_prev_r;
  logic press, gp_edge;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      btn_prev_r <= 1'b0;
      gp_prev_r  <= 1'b0;
    end else begin
      btn_prev_r <= btn_d;
      gp_prev_r  <= gpulse;
    end
  end
  assign press   = btn_d & ~btn_prev_r;
  assign gp_edge = gpulse & ~gp_prev_r;

  ////////////////////////////////////////////////////////////////////////
  // fault and emergency conditions
  logic wchk_r;
  logic fault, emergency, start_ok;
  assign fault     = ~power_ok_i | speed_fault_i | pos_fault_i
                   | write_fault_i;
  assign emergency = fault | ext_req | wchk_r;
  assign start_ok  = seated & power_ok_i & ~fault & ~ext_req
                   & ~wchk_r;

  // write-check latch; a new fault wins over the press clear
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wchk_r <= 1'b0;
    end else if (write_fault_i) begin
      wchk_r <= 1'b1;
    end else if (press) begin
      wchk_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // run/stop state machine
  dss_pkg::dss_state_e state_r, state_nxt;
  logic ctl_prev_r;
  logic ctl_start_req, ctl_stop_req;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctl_prev_r <= 1'b0;
    end else begin
      ctl_prev_r <= ctl_start_i;
    end
  end
  // start/stop line acts regardless of unit select
  assign ctl_start_req = ctl_start_i & ~ctl_prev_r;
  assign ctl_stop_req  = ~ctl_start_i & ctl_prev_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      dss_pkg::DSS_IDLE: begin
        if (emergency) begin
          state_nxt = dss_pkg::DSS_EMER;
        end else if ((press | ctl_start_req) && start_ok) begin
          state_nxt = dss_pkg::DSS_RUN;
        end
      end
      dss_pkg::DSS_RUN: begin
        if (emergency) begin
          state_nxt = dss_pkg::DSS_EMER;
        end else if (press | ctl_stop_req) begin
          state_nxt = dss_pkg::DSS_STOP;
        end
      end
      dss_pkg::DSS_STOP: begin
        if (emergency) begin
          state_nxt = dss_pkg::DSS_EMER;
        end else if (!disk_rotating_i && heads_retracted_i) begin
          state_nxt = dss_pkg::DSS_IDLE;
        end
      end
      dss_pkg::DSS_EMER: begin
        if (!emergency && !disk_rotating_i && heads_retracted_i) begin
          state_nxt = dss_pkg::DSS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= dss_pkg::DSS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lamps, spindle, head unload and cartridge lock
  logic safe_nxt;
  assign safe_nxt = power_ok_i & ~disk_rotating_i & heads_retracted_i
                  & ~emergency
                  & (state_nxt == dss_pkg::DSS_IDLE);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      run_lamp_o  <= 1'b0;
      spin_en_o   <= 1'b0;
      unload_o    <= 1'b0;
      safe_lamp_o <= 1'b0;
      cart_lock_o <= 1'b1;
    end else begin
      run_lamp_o  <= (state_nxt == dss_pkg::DSS_RUN);
      spin_en_o   <= (state_nxt == dss_pkg::DSS_RUN);
      // emergency retracts at once; a stop waits for write/erase
      unload_o    <= (state_nxt == dss_pkg::DSS_EMER)
                   | ((state_nxt == dss_pkg::DSS_STOP)
                      & ~write_active_i);
      safe_lamp_o <= safe_nxt;
      cart_lock_o <= ~safe_nxt;
    end
  end

  a_run_dark_emer: assert property (@(posedge mclk_i) disable iff (rst_i)
    emergency |=> !run_lamp_o)
    else $error("run lamp lit during emergency");
  a_lock_vs_safe: assert property (@(posedge mclk_i) disable iff (rst_i)
    cart_lock_o == !safe_lamp_o)
    else $error("cartridge lock not inverse of safe lamp");
  a_safe_cond: assert property (@(posedge mclk_i) disable iff (rst_i)
    safe_lamp_o |-> $past(power_ok_i) && !$past(disk_rotating_i)
                    && $past(heads_retracted_i))
    else $error("safe lamp lit while unsafe");
  a_ext_unload: assert property (@(posedge mclk_i) disable iff (rst_i)
    ext_req |=> unload_o)
    else $error("retract request did not unload heads");
  a_fault_unload: assert property (@(posedge mclk_i) disable iff (rst_i)
    (pos_fault_i || speed_fault_i || !power_ok_i) |=> unload_o)
    else $error("fault did not unload heads");
  a_stop_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_r == dss_pkg::DSS_STOP && write_active_i && !emergency)
      |=> !unload_o)
    else $error("heads unloaded during write in stop");
  a_start_refused: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_r == dss_pkg::DSS_IDLE && !start_ok) |=> !run_lamp_o)
    else $error("started while start inhibited");
  a_wchk_unsafe: assert property (@(posedge mclk_i) disable iff (rst_i)
    wchk_r |=> !safe_lamp_o)
    else $error("safe after write fault without press");

  ////////////////////////////////////////////////////////////////////////
  // write guard: switches plus latched per-disk controller guard
  logic [dss_pkg::FIXED-1:0] soft_guard_r;
  logic up_guard_r, lo_guard_r;
  logic [dss_pkg::FIXED-1:0] fix_guard;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      soft_guard_r <= '0;
    end else if (gp_edge && selected_o && !lo_sw
                 && fixed_sel_i < 2'(dss_pkg::FIXED)) begin
      soft_guard_r[fixed_sel_i] <= 1'b1;
    end else if (press && !write_active_i) begin
      soft_guard_r <= '0;
    end
  end

  // switch state applied only between write/erase operations
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      up_guard_r <= 1'b0;
      lo_guard_r <= 1'b0;
    end else if (!write_active_i) begin
      up_guard_r <= up_sw;
      lo_guard_r <= lo_sw;
    end
  end

  assign fix_guard = {dss_pkg::FIXED{lo_guard_r}} | soft_guard_r;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      write_guard_lamp_upper_o <= 1'b0;
      write_guard_lamp_lower_o <= 1'b0;
      write_inhibit_o          <= 1'b1;
    end else begin
      write_guard_lamp_upper_o <= up_guard_r;
      // lamps show switch state; controller guard only inhibits
      write_guard_lamp_lower_o <= lo_guard_r;
      write_inhibit_o <= removable_sel_i ? up_guard_r
                       : (fixed_sel_i < 2'(dss_pkg::FIXED)
                          ? fix_guard[fixed_sel_i] : 1'b1);
    end
  end

  a_guard_frozen: assert property (@(posedge mclk_i) disable iff (rst_i)
    (write_active_i && $past(write_active_i))
      |-> $stable(up_guard_r) && $stable(lo_guard_r))
    else $error("guard changed during write");

  ////////////////////////////////////////////////////////////////////////
  // unit number decode on the shared daisy-chained bus
  logic [1:0] unit_idx;
  logic [1:0] unit_sw_r;
  logic [3:0] sel;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      unit_sw_r <= dss_pkg::UNIT_DEF;
    end else if (!write_active_i) begin
      unit_sw_r <= unit_sw_i;
    end
  end

  assign unit_idx = HAS_SWITCH ? unit_sw_r : FIXED_UNIT;
  assign sel      = ~unit_sel_n_i;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      selected_o   <= 1'b0;
      split_half_o <= 1'b0;
    end else if (split_en_i) begin
      // pair of adjacent units: even answers half 0, odd answers half 1
      selected_o   <= sel[{unit_idx[1], 1'b0}]
                    | sel[{unit_idx[1], 1'b1}];
      split_half_o <= sel[{unit_idx[1], 1'b1}];
    end else begin
      selected_o   <= sel[unit_idx];
      split_half_o <= 1'b0;
    end
  end

  a_sel_decode: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!split_en_i && HAS_SWITCH && $stable(unit_sw_r))
      |=> selected_o == !$past(unit_sel_n_i[unit_sw_r]))
    else $error("unit select decode wrong");

endmodule : dss_top

// >>> include/dss_pkg.sv
// dss_pkg: constants and types for the drive safety supervisor.
// assumes a 100 MHz core clock; all counts are in mclk_i cycles.
package dss_pkg;
  localparam int unsigned CLK_MHZ      = 100;
  // debounce settle time in microseconds
  localparam int unsigned DEB_US       = 20;
  localparam int unsigned DEB_CYC      = DEB_US * CLK_MHZ;
  localparam int unsigned DEB_W        = 12;
  // number of unit-select lines on the shared bus
  localparam int unsigned UNITS        = 4;
  // default unit index when no switch is fitted (line one)
  localparam logic [1:0]  UNIT_DEF     = 2'h0;
  // number of fixed disks that can be guarded individually
  localparam int unsigned FIXED        = 3;
  // run state machine
  typedef enum logic [1:0] {
    DSS_IDLE,
    DSS_RUN,
    DSS_STOP,
    DSS_EMER
  } dss_state_e;
endpackage : dss_pkg

// >>> tb/dss_ctl_model.sv
// dss_ctl_model: controller side of the shared drive bus.
// assumes bench commands change just after a rising mclk_i edge.
`timescale 1ns/1ps
module dss_ctl_model #(
  parameter int unsigned PULSE_CYC = 12
) (
  input  wire logic       mclk_i,
  input  wire logic       sel_en_i,
  input  wire logic [1:0] unit_i,
  input  wire logic       retract_i,
  input  wire logic       start_i,
  input  wire logic       guard_go_i,
  output logic [3:0]      unit_sel_n_o,
  output logic            ext_retract_req_n_o,
  output logic            ctl_start_o,
  output logic            guard_pulse_n_o
);
  logic [4:0] pulse_cnt_r = 5'h00;

  // one low select line at a time, all high when no drive is wanted
  assign unit_sel_n_o = sel_en_i ? ~(4'h1 << unit_i) : 4'hF;
  assign ext_retract_req_n_o = ~retract_i;
  assign ctl_start_o = start_i;
  assign guard_pulse_n_o = (pulse_cnt_r == 5'h00);

  ////////////////////////////////////////////////////////////////////////////
  // guard pulse long enough to pass the drive's debounce
  always @(posedge mclk_i) begin
    if (guard_go_i) begin
      pulse_cnt_r <= 5'(PULSE_CYC);
    end else if (pulse_cnt_r != 5'h00) begin
      pulse_cnt_r <= pulse_cnt_r - 5'h01;
    end
  end
endmodule : dss_ctl_model

// >>> tb/test_dss_top.sv
// test_dss_top: directed bench for the drive safety supervisor.
// assumes debounce shortened to 4 cycles; controller model on the bus.
`timescale 1ns/1ps
module test_dss_top;
  localparam int DEB = 4;
  localparam int RUN = 0, UNL = 2, SAFE = 3, LOCK = 4, GU = 5, GL = 6;
  localparam int WI = 7, SEL = 8, HALF = 9, FSEL = 10;
  logic mclk_i = 1'b0, rst_i = 1'b1, btn = 1'b0, gu_sw = 1'b0, gl_sw = 1'b0;
  logic seated = 1'b0, pwr = 1'b1, rot = 1'b0, hret = 1'b1, wr_act = 1'b0;
  logic split = 1'b0, rem = 1'b1, sel_en = 1'b1, retract = 1'b0;
  logic start = 1'b0, guard_go = 1'b0, pulse_n, retract_n, ctl_start;
  logic [2:0] flt = 3'h0;
  logic [1:0] unit_sw = 2'h0, unit = 2'h0, fsel = 2'h3;
  logic [3:0] sel_n;
  logic [10:0] outs;
  int errors = 0, n_checks = 0;
  string nm[11] = '{"run_lamp", "spin_en", "unload", "safe_lamp", "cart_lock",
                    "lamp_upper", "lamp_lower", "inhibit", "selected", "half",
                    "sel_fixed"};

  always #5 mclk_i = ~mclk_i;

  dss_ctl_model ctl (.mclk_i(mclk_i), .sel_en_i(sel_en), .unit_i(unit),
    .retract_i(retract), .start_i(start), .guard_go_i(guard_go),
    .unit_sel_n_o(sel_n), .ext_retract_req_n_o(retract_n),
    .ctl_start_o(ctl_start), .guard_pulse_n_o(pulse_n));

  dss_top #(.DEB_CYC(DEB)) dut (.mclk_i(mclk_i), .rst_i(rst_i),
    .run_stop_btn_i(btn), .guard_upper_sw_i(gu_sw), .guard_lower_sw_i(gl_sw),
    .ext_retract_req_n_i(retract_n), .cart_seated_i(seated),
    .power_ok_i(pwr), .disk_rotating_i(rot), .heads_retracted_i(hret),
    .speed_fault_i(flt[0]), .pos_fault_i(flt[1]), .write_fault_i(flt[2]),
    .write_active_i(wr_act), .unit_sw_i(unit_sw), .split_en_i(split),
    .unit_sel_n_i(sel_n), .guard_pulse_n_i(pulse_n), .fixed_sel_i(fsel),
    .ctl_start_i(ctl_start), .removable_sel_i(rem), .run_lamp_o(outs[0]),
    .spin_en_o(outs[1]), .unload_o(outs[2]), .safe_lamp_o(outs[3]),
    .cart_lock_o(outs[4]), .write_guard_lamp_upper_o(outs[5]),
    .write_guard_lamp_lower_o(outs[6]), .write_inhibit_o(outs[7]),
    .selected_o(outs[8]), .split_half_o(outs[9]));

  // build-time unit number, no thumbwheel fitted
  dss_top #(.DEB_CYC(DEB), .HAS_SWITCH(1'b0), .FIXED_UNIT(2'h2)) dut_fix (
    .mclk_i(mclk_i), .rst_i(rst_i), .run_stop_btn_i(btn),
    .guard_upper_sw_i(gu_sw), .guard_lower_sw_i(gl_sw),
    .ext_retract_req_n_i(retract_n), .cart_seated_i(seated),
    .power_ok_i(pwr), .disk_rotating_i(rot), .heads_retracted_i(hret),
    .speed_fault_i(flt[0]), .pos_fault_i(flt[1]), .write_fault_i(flt[2]),
    .write_active_i(wr_act), .unit_sw_i(unit_sw), .split_en_i(split),
    .unit_sel_n_i(sel_n), .guard_pulse_n_i(pulse_n), .fixed_sel_i(fsel),
    .ctl_start_i(ctl_start), .removable_sel_i(rem), .run_lamp_o(),
    .spin_en_o(), .unload_o(), .safe_lamp_o(), .cart_lock_o(),
    .write_guard_lamp_upper_o(), .write_guard_lamp_lower_o(),
    .write_inhibit_o(), .selected_o(outs[FSEL]), .split_half_o());

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [10:0] seen, input logic [10:0] exp,
                     input string what);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // bounded wait for an output level, then compare
  task automatic wait_bit(input int i, input logic e, input int max);
    int n;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (outs[i] !== e && n < max);
    chk(outs[i], e, nm[i]);
    if (outs[i] !== e) begin
      report_and_stop();
    end
    // return on a rising edge so callers drive inputs there
    @(posedge mclk_i);
  endtask : wait_bit

  task automatic hold_bit(input int i, input logic e, input int n);
    repeat (n) @(negedge mclk_i);
    chk(outs[i], e, nm[i]);
    @(posedge mclk_i);
  endtask : hold_bit

  task automatic press();
    @(posedge mclk_i);
    btn <= 1'b1;
    repeat (DEB + 8) @(posedge mclk_i);
    btn <= 1'b0;
    repeat (DEB + 8) @(posedge mclk_i);
  endtask : press

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (7) @(posedge mclk_i);
    @(negedge mclk_i);
    chk(outs, 11'h090, "reset outputs");
    @(posedge mclk_i);
    rst_i <= 1'b0;
    wait_bit(SAFE, 1'b1, 40);
    hold_bit(LOCK, 1'b0, 1);
    press();
    hold_bit(RUN, 1'b0, 1);
    seated <= 1'b1;
    press();
    hold_bit(RUN, 1'b1, 1);
    hold_bit(1, 1'b1, 1);
    rot <= 1'b1;
    hret <= 1'b0;
    wr_act <= 1'b1;
    gu_sw <= 1'b1;
    wait_bit(SAFE, 1'b0, 3);
    hold_bit(LOCK, 1'b1, 1);
    press();
    hold_bit(RUN, 1'b0, 1);
    hold_bit(GU, 1'b0, 1);
    hold_bit(UNL, 1'b0, 10);
    @(posedge mclk_i);
    wr_act <= 1'b0;
    wait_bit(UNL, 1'b1, 3);
    wait_bit(GU, 1'b1, 20);
    wait_bit(WI, 1'b1, 3);
    hold_bit(SAFE, 1'b0, 10);
    rot <= 1'b0;
    hret <= 1'b1;
    gu_sw <= 1'b0;
    wait_bit(SAFE, 1'b1, 10);
    wait_bit(GU, 1'b0, 20);
    wait_bit(WI, 1'b0, 3);
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk_i);
      if (k == 0) pwr <= 1'b0;
      else flt[k-1] <= 1'b1;
      wait_bit(UNL, 1'b1, 2);
      @(posedge mclk_i);
      pwr <= 1'b1;
      flt <= 3'h0;
      if (k < 3) wait_bit(SAFE, 1'b1, 20);
    end
    hold_bit(SAFE, 1'b0, 30);
    press();
    wait_bit(SAFE, 1'b1, 40);
    retract <= 1'b1;
    wait_bit(UNL, 1'b1, 20);
    press();
    hold_bit(RUN, 1'b0, 1);
    retract <= 1'b0;
    wait_bit(SAFE, 1'b1, 30);
    rem <= 1'b0;
    fsel <= 2'h1;
    guard_go <= 1'b1;
    @(posedge mclk_i);
    guard_go <= 1'b0;
    wait_bit(WI, 1'b1, 30);
    fsel <= 2'h2;
    wait_bit(WI, 1'b0, 3);
    gl_sw <= 1'b1;
    wait_bit(WI, 1'b1, 20);
    wait_bit(GL, 1'b1, 3);
    gl_sw <= 1'b0;
    fsel <= 2'h1;
    wait_bit(GL, 1'b0, 20);
    hold_bit(WI, 1'b1, 1);
    press();
    wait_bit(WI, 1'b0, 30);
    press();
    for (int s = 0; s < 4; s++) begin
      for (int u = 0; u < 4; u++) begin
        unit_sw <= 2'(s);
        unit <= 2'(u);
        hold_bit(SEL, s == u, 3);
        hold_bit(FSEL, u == 2, 1);
      end
    end
    sel_en <= 1'b0;
    hold_bit(SEL, 1'b0, 3);
    sel_en <= 1'b1;
    split <= 1'b1;
    unit_sw <= 2'h0;
    for (int u = 0; u < 4; u++) begin
      unit <= 2'(u);
      hold_bit(SEL, u < 2, 3);
      hold_bit(HALF, u == 1, 1);
    end
    split <= 1'b0;
    sel_en <= 1'b0;
    start <= 1'b1;
    wait_bit(RUN, 1'b1, 3);
    start <= 1'b0;
    wait_bit(RUN, 1'b0, 3);
    seated <= 1'b0;
    hold_bit(SAFE, 1'b1, 12);
    start <= 1'b1;
    hold_bit(RUN, 1'b0, 4);
    report_and_stop();
  end
endmodule : test_dss_top
